// ---- design/rptr_tx_core.sv ----
// Transmit and collision control of a twelve-port repeater controller.
// Assumes the PHYs share core_clk as transmit reference and run in repeater mode.
// Function
// [R1] Send repeated data as one 4-bit nibble per reference clock cycle.
// [R2] Active carrier sense enables transmit on all idle ports with repeated data.
// [R3] Receive error indication is repeated as transmit error at that point.
// [R4] PHY asserts carrier sense only while receiving, not while transmitting.
// [R5] Carrier sense on two or more ports at once is a collision.
// [R6] After collision, jam goes to all ports until transmission period ends.
// [R7] PHY strap high selects repeater mode, low selects node mode.
// [R8] Node-mode PHY senses carrier both ways and flags collision itself.
// [R9] Twelve separate transmit enables; only data and error are shared.
// [R10] Controller and PHYs share one reference clock; returned transmit clock unused.
// [R11] Board loops collision output directly back to collision input.
// [R12] Active carrier enables that port's receive path; only one at a time.
// [R13] Each carrier sense input is synchronised before use.
// [R14] Transmit enables drop once all carrier is gone and last nibble sent.
`timescale 1ns/10ps
module rptr_tx_core
  import rptr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic [NUM_PORTS-1:0] carrier_sense,
  input  wire rx_stream_t           rx_stream,
  input  wire logic                 collision_in_n,
  output logic      [NUM_PORTS-1:0] port_transmit_enable,
  output logic      [NUM_PORTS-1:0] port_receive_enable_n,
  output tx_bus_t                   tx_bus,
  output logic                      collision_out_n,
  output logic                      collision_oe
);
  typedef enum logic [1:0] {ST_IDLE, ST_REPEAT, ST_JAM} phase_t;

  typedef struct packed {
    phase_t               phase;
    logic [NUM_PORTS-1:0] rx_sel;
    logic [NUM_PORTS-1:0] tx_en;
    tx_bus_t              tx;
    logic                 col_drv;
  } state_t;

  state_t               st_q;
  state_t               st_d;
  logic [NUM_PORTS-1:0] crs;
  logic [NUM_PORTS-1:0] first_hot;
  logic                 any_crs;
  logic                 multi_crs;
  logic                 col_seen;

  crs_sync u_crs_sync (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .crs_async  (carrier_sense),
    .crs_sync_o (crs)
  );

  // ----------------------------------------------------------------
  // Carrier decode
  // ----------------------------------------------------------------
  // Lowest-numbered active port wins the receive bus
  assign first_hot = crs & (~crs + {{(NUM_PORTS-1){1'b0}}, 1'b1});
  assign any_crs   = |crs;
  assign multi_crs = (crs & ~first_hot) != '0;                         // [R5]
  // Looped-back collision line also covers other controllers on the wire
  assign col_seen  = multi_crs || !collision_in_n;                     // [R11]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d         = st_q;
    st_d.col_drv = multi_crs;
    case (st_q.phase)
      ST_IDLE:
      begin
        st_d.tx     = '0;
        st_d.tx_en  = '0;
        st_d.rx_sel = '0;
        if (any_crs)
        begin
          st_d.rx_sel = first_hot;                                     // [R12]
          st_d.tx_en  = ~crs;                                          // [R2] [R9]
          st_d.phase  = ST_REPEAT;
          if (col_seen)
          begin
            // Collision at the very start goes straight to jam on all ports
            st_d.phase  = ST_JAM;
            st_d.rx_sel = '0;
            st_d.tx_en  = '1;                                          // [R6]
            st_d.tx     = '{er: 1'b0, data: JAM_NIB};
          end
        end
      end
      ST_REPEAT:
      begin
        st_d.tx.data = rx_stream.data;                                 // [R1]
        st_d.tx.er   = rx_stream.er;                                   // [R3]
        st_d.tx_en   = st_q.tx_en & ~crs;
        if (col_seen)
        begin
          st_d.phase  = ST_JAM;
          st_d.rx_sel = '0;
          st_d.tx_en  = '1;                                            // [R6]
          st_d.tx     = '{er: 1'b0, data: JAM_NIB};
        end
        else if (!any_crs)
        begin
          // Last repeated nibble went out this cycle
          st_d.phase  = ST_IDLE;
          st_d.tx_en  = '0;                                            // [R14]
          st_d.rx_sel = '0;
          st_d.tx     = '0;
        end
      end
      ST_JAM:
      begin
        // Held until carrier is gone and the collision line is released
        st_d.tx_en  = '1;                                              // [R6]
        st_d.rx_sel = '0;
        st_d.tx     = '{er: 1'b0, data: JAM_NIB};
        if (!any_crs && collision_in_n)
        begin
          st_d.phase = ST_IDLE;
          st_d.tx_en = '0;                                             // [R14]
          st_d.tx    = '0;
        end
      end
      default:
      begin
        st_d = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Transmit timed from core_clk only; no returned transmit clock exists [R10]
  // No port owns the receive bus while jamming
  assign port_transmit_enable  = st_q.tx_en;
  assign port_receive_enable_n = ~st_q.rx_sel;
  assign tx_bus                = st_q.tx;
  // Open-drain: drive low only while colliding
  assign collision_out_n       = 1'b0;
  assign collision_oe          = st_q.col_drv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_two_crs;
    $countones(crs) >= 2;
  endsequence

  sequence s_jam_out;
    st_q.phase == ST_JAM && port_transmit_enable == '1 && tx_bus.data == JAM_NIB;
  endsequence

  a_collision_to_jam: assert property (  // [R5] [R6]
    @(posedge core_clk) disable iff (!resetn) s_two_crs |=> s_jam_out)
    else $error("collision did not start jam");

  a_jam_holds_on: assert property (  // [R6]
    @(posedge core_clk) disable iff (!resetn) (st_q.phase == ST_JAM && any_crs) |=> s_jam_out)
    else $error("jam ended while carrier active");

  a_rx_one_hot: assert property (  // [R12]
    @(posedge core_clk) disable iff (!resetn) $onehot0(~port_receive_enable_n))
    else $error("more than one receive enable");

  a_rx_follows_crs: assert property (  // [R12]
    @(posedge core_clk) disable iff (!resetn)
    (st_q.phase == ST_IDLE && $countones(crs) == 1 && collision_in_n) |=> (~port_receive_enable_n == $past(crs)))
    else $error("receive enable not on carrier port");

  a_tx_idle_ports: assert property (  // [R2] [R9]
    @(posedge core_clk) disable iff (!resetn)
    (st_q.phase == ST_IDLE && $countones(crs) == 1 && collision_in_n) |=> (port_transmit_enable == ~$past(crs)))
    else $error("transmit enable not on idle ports");

  a_nibble_repeat: assert property (  // [R1] [R3]
    @(posedge core_clk) disable iff (!resetn)
    (st_q.phase == ST_REPEAT && any_crs && !col_seen) |=> (tx_bus.data == $past(rx_stream.data) && tx_bus.er == $past(rx_stream.er)))
    else $error("nibble or error not repeated");

  a_tx_drop_end: assert property (  // [R14]
    @(posedge core_clk) disable iff (!resetn)
    (st_q.phase != ST_IDLE && !any_crs && collision_in_n) |=> port_transmit_enable == '0)
    else $error("transmit enable held after carrier end");

  a_col_out_drive: assert property (  // [R11]
    @(posedge core_clk) disable iff (!resetn) s_two_crs |=> (collision_oe && !collision_out_n))
    else $error("collision output not driven");

  // Raw carrier must never move the state; only the synchronised copy may
  sequence s_idle_no_crs;
    st_q.phase == ST_IDLE && !any_crs;
  endsequence

  a_idle_waits_sync: assert property (  // [R13]
    @(posedge core_clk) disable iff (!resetn) s_idle_no_crs |=> st_q.phase == ST_IDLE)
    else $error("left idle without synchronised carrier");

  a_idle_quiet: assert property (  // [R14]
    @(posedge core_clk) disable iff (!resetn)
    st_q.phase == ST_IDLE |-> (port_transmit_enable == '0 && tx_bus == '0 && port_receive_enable_n == '1))
    else $error("idle with enables or data active");

  // Receiving port must not be sent its own packet back
  a_repeat_skips_rx: assert property (  // [R2] [R9]
    @(posedge core_clk) disable iff (!resetn)
    st_q.phase == ST_REPEAT |-> ((port_transmit_enable & ~port_receive_enable_n) == '0))
    else $error("receiving port also transmits");

  a_col_only_multi: assert property (  // [R5]
    @(posedge core_clk) disable iff (!resetn) !multi_crs |=> !collision_oe)
    else $error("collision driven without two carriers");
endmodule

// ---- design/rptr_pkg.sv ----
// Shared constants and bus types for the repeater transmit/collision block.
// Assumes one core clock shared with all PHYs; no software-visible registers.
package rptr_pkg;
  localparam int         NUM_PORTS = 12;
  localparam int         NIB_W     = 4;
  localparam logic [3:0] JAM_NIB   = 4'h5;  // Alternating 0101 pattern
  localparam int         SYNC_STG  = 2;

  // Repeated receive stream from the shared receive bus
  typedef struct packed {
    logic             dv;
    logic             er;
    logic [NIB_W-1:0] data;
  } rx_stream_t;

  // Shared transmit bus towards all PHYs
  typedef struct packed {
    logic             er;
    logic [NIB_W-1:0] data;
  } tx_bus_t;
endpackage

// ---- design/crs_sync.sv ----
// Two-stage synchroniser bank for the per-port carrier sense lines.
// Assumes carrier sense is asynchronous to core_clk.
`timescale 1ns/10ps
module crs_sync
  import rptr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic [NUM_PORTS-1:0] crs_async,
  output logic      [NUM_PORTS-1:0] crs_sync_o
);
  logic [NUM_PORTS-1:0] meta_q;
  logic [NUM_PORTS-1:0] sync_q;

  // First stage is read only by the second stage
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_sync
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= crs_async[g];  // [R13]
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign crs_sync_o = sync_q;
endmodule

// ---- tb/phy_bank.sv ----
// Twelve repeater-mode PHYs on the shared receive bus, one behavioural model.
// Assumes the bench says which ports receive and whether they flag errors.
`timescale 1ns/10ps
module phy_bank
  import rptr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic [NUM_PORTS-1:0] receiving,
  input  wire logic                 rx_err,
  input  wire logic [NUM_PORTS-1:0] port_receive_enable_n,
  input  wire logic [NUM_PORTS-1:0] port_transmit_enable,
  output logic      [NUM_PORTS-1:0] carrier_sense,
  output rx_stream_t                rx_stream
);
  logic [3:0] nib = 4'h0;
  initial rx_stream = '0;
  // Strap high: carrier only for reception; node mode would echo our transmit
  localparam logic MODE_STRAP = 1'b1;
  assign carrier_sense = MODE_STRAP ? receiving : (receiving | port_transmit_enable);
  always @(posedge core_clk)
  begin
    nib <= nib + 4'h3;
    if ($countones(~port_receive_enable_n) == 1)
      rx_stream <= '{dv: 1'b1, er: rx_err, data: nib};
    else
      rx_stream <= ~rx_stream; // Released bus shows no stale value
  end
endmodule

// ---- tb/rptr_tx_core_tb_top.sv ----
// Self-checking bench for the repeater transmit and collision core.
// Assumes the phy_bank model and a pulled-up collision loop wire.
`timescale 1ns/10ps
module rptr_tx_core_tb_top;
  import rptr_pkg::*;
  logic                 core_clk   = 1'b0;
  logic                 resetn     = 1'b0;
  logic                 rx_err     = 1'b0;
  logic [NUM_PORTS-1:0] receiving  = '0;
  logic [NUM_PORTS-1:0] crs, tx_en, rx_en_n;
  rx_stream_t           rx_stream;
  tx_bus_t              tx_bus;
  logic                 col_out_n, col_oe, col_in_n;
  int                   mismatches = 0;
  int                   tests_run  = 0;
  int                   seed       = 2;
  int                   a;
  // Board loop-back with pull-up
  assign col_in_n = col_oe ? col_out_n : 1'b1;
  rptr_tx_core rptr_tx_core_i (.core_clk(core_clk), .resetn(resetn), .carrier_sense(crs),
    .rx_stream(rx_stream), .collision_in_n(col_in_n), .port_transmit_enable(tx_en),
    .port_receive_enable_n(rx_en_n), .tx_bus(tx_bus), .collision_out_n(col_out_n), .collision_oe(col_oe));
  phy_bank phy_bank_i (.core_clk(core_clk), .receiving(receiving), .rx_err(rx_err),
    .port_receive_enable_n(rx_en_n), .port_transmit_enable(tx_en), .carrier_sense(crs), .rx_stream(rx_stream));
  initial forever #50 core_clk = ~core_clk;
  task automatic note(string n, logic [11:0] e, logic [11:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_en(string n, logic [NUM_PORTS-1:0] e, logic [NUM_PORTS-1:0] g);
    note(n, e, g);
  endtask
  task automatic chk_bus(tx_bus_t e, tx_bus_t g);
    note("tx_bus", {7'h0, e}, {7'h0, g});
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    note(n, {11'h0, e}, {11'h0, g});
  endtask
  function automatic logic [NUM_PORTS-1:0] idle_ports(int p);
    return ~(12'h1 << p);
  endfunction
  function automatic tx_bus_t jam_bus();
    return '{er: 1'b0, data: JAM_NIB};
  endfunction
  task automatic summarize;
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait: a stuck enable still ends in a compare
  task automatic drop(int lim);
    @(posedge core_clk);
    receiving <= '0;
    repeat (lim)
    begin
      @(posedge core_clk);
      #1;
      if (tx_en === '0 && col_oe === 1'b0)
        break;
    end
    chk_en("tx_en", '0, tx_en);
    chk_en("rx_en_n", '1, rx_en_n);
    @(posedge core_clk);
  endtask
  task automatic packet(int p, int len, logic err);
    logic [NUM_PORTS-1:0] m;
    tx_bus_t              e;
    m = ~idle_ports(p);
    @(posedge core_clk);
    receiving <= m;
    rx_err    <= err;
    repeat (3) @(posedge core_clk);
    #1;
    chk_en("rx_en_n", idle_ports(p), rx_en_n);
    chk_en("tx_en", idle_ports(p), tx_en);
    for (int i = 0; i < len; i++)
    begin
      @(posedge core_clk);
      e = '{er: rx_stream.er, data: rx_stream.data};
      #1;
      chk_bus(e, tx_bus);
      // First nibble is the bus from before the port was enabled
      if (i > 0)
        chk_bit("tx_er", err, tx_bus.er);
    end
    drop(3);
  endtask
  task automatic collide(int x, int y, int gap);
    @(posedge core_clk);
    if (gap > 0)
    begin
      receiving <= 12'h1 << x;
      repeat (gap) @(posedge core_clk);
    end
    receiving <= (12'h1 << x) | (12'h1 << y);
    repeat (3) @(posedge core_clk);
    repeat (4)
    begin
      #1;
      chk_en("tx_en", '1, tx_en);
      chk_bus(jam_bus(), tx_bus);
      chk_bit("col_oe", 1'b1, col_oe);
      chk_bit("col_out_n", 1'b0, col_out_n);
      chk_bit("one_rx_en", 1'b1, $countones(~rx_en_n) <= 1);
      @(posedge core_clk);
    end
    drop(12);
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    chk_en("tx_en", '0, tx_en);
    chk_en("rx_en_n", '1, rx_en_n);
    chk_bit("col_oe", 1'b0, col_oe);
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    packet(0, 8, 1'b0);
    packet(11, 8, 1'b1);
    repeat (6) packet($unsigned($random(seed)) % 12, 5, $random(seed));
    // Reset in mid-packet must drop every enable at once
    @(posedge core_clk);
    receiving <= 12'h1 << 4;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    #1;
    chk_en("tx_en", '0, tx_en);
    chk_en("rx_en_n", '1, rx_en_n);
    @(posedge core_clk);
    receiving <= '0;
    resetn    <= 1'b1;
    collide(0, 11, 0);
    collide(5, 2, 6);
    repeat (4)
    begin
      a = $unsigned($random(seed)) % 12;
      collide(a, (a + 1 + $unsigned($random(seed)) % 11) % 12, $unsigned($random(seed)) % 4);
    end
    summarize;
  end
  initial
  begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule
